// *** hdl/pfp_device.sv ***
/*
 * device end: paged register file with fuse lock, fuse write, force power and loop status.
 * assumes link clock slower than a quarter of clk_sys; lock_loss and loop_state on clk_sys.
 */
`timescale 1ns/1ps
module pfp_device (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       reset_n,
	input  wire logic       ce,
	// link
	pfp_link_if.dev         link,
	// loop status from the loop controllers
	input  wire logic [3:0] lock_loss,
	input  wire logic [7:0] loop_state,
	// subsystem control
	output logic      [6:0] subsys_power_up,
	output logic      [6:0] subsys_force,
	output logic            manual_wake_en,
	output logic      [7:0] page_fuse_locked,
	output logic            fuse_write_start,
	output logic      [2:0] fuse_write_page,
	output logic      [3:0] lock_loss_notify
);
	typedef struct packed {
		pfp_pkg::pfp_dev_st_t st;        // frame state
		logic [4:0]           cnt;       // bits left in field
		logic                 rw;        // 1 = read
		logic [7:0]           addr;      // register offset
		logic [7:0]           sh;        // data shift register
		logic [7:0]           page;      // selected page code
		logic [7:0][7:0]      lock_cfg;  // per-page lock config
		logic [7:0][7:0]      stsel;     // per-page readback select
		logic [3:0]           mask;      // per-loop notify mask
		logic [3:0]           notify;    // per-loop sticky notify
		logic [6:0]           force_ovr; // main page override
		logic [6:0]           force_en;  // main page enable
		logic [6:0]           pwr;       // power-up result
		logic [7:0]           locked;    // lock field decode
		logic                 miso;      // serial out
		logic                 fw;        // fuse write pulse
		logic [2:0]           fw_page;   // page of that write
		logic                 wake;      // manual wake-up still in force
	} pfp_dev_t;
	pfp_dev_t s, next_s;
	logic [2:0] lk_q, lk_rise, lk_fall; // {sel_n, mosi, link_clk}
	////////////////////////////////////////////////////////////////////////////
	// bring link pins into clk_sys
	pfp_sync #(.WIDTH(3)) u_sync (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.ce      (ce),
		.din     ({link.sel_n, link.mosi, link.link_clk}),
		.q       (lk_q),
		.rise    (lk_rise),
		.fall    (lk_fall)
	);
	// loop state to readback code
	function automatic logic [7:0] state_code(input logic [1:0] st);
		case (st)
			pfp_pkg::LST_WAIT:   state_code = pfp_pkg::CODE_WAIT;
			pfp_pkg::LST_ACTIVE: state_code = pfp_pkg::CODE_ACTIVE;
			default:             state_code = pfp_pkg::CODE_IDLE;
		endcase
	endfunction
	////////////////////////////////////////////////////////////////////////////
	// frame decode and register file
	always_comb
	begin
		logic [3:0] pi;
		logic       is_loop;
		logic       is_main;
		logic [1:0] li;
		logic [7:0] rd;
		logic [7:0] wd;
		pi      = pfp_pkg::page_index(s.page);
		is_loop = pi[3] & pi[2];
		is_main = pi[3] & (pi[2:0] == 3'h0);
		li      = pi[1:0];
		rd      = 8'h00;
		wd      = {s.sh[6:0], lk_q[1]};
		next_s  = s;
		next_s.fw = 1'b0;
		// sticky notify, set wins over a clearing write
		next_s.notify = s.notify | (lock_loss & s.mask);
		// read mux in the current page
		if (s.addr == pfp_pkg::OFS_PAGE)
			rd = s.page;
		else if (pi[3])
		begin
			case (s.addr)
				pfp_pkg::OFS_LOCK:  rd = s.lock_cfg[pi[2:0]];
				pfp_pkg::OFS_STSEL: rd = s.stsel[pi[2:0]];
				pfp_pkg::OFS_STATE:
					if (is_loop && s.stsel[pi[2:0]] == pfp_pkg::STSEL_LOOP)
						rd = state_code(loop_state[2*li +: 2]);
				pfp_pkg::OFS_LIVE:
					if (is_loop)
						rd = {7'h00, lock_loss[li]};
				pfp_pkg::OFS_NOTIFY:
					if (is_loop)
						rd = {7'h00, s.notify[li]};
				pfp_pkg::OFS_MASK:
					if (is_loop)
						rd = {7'h00, s.mask[li]};
				pfp_pkg::OFS_FORCE:
					if (is_main)
						rd = {1'b0, s.force_ovr};
				pfp_pkg::OFS_ENABLE:
					if (is_main)
						rd = {1'b0, s.force_en};
				default: rd = 8'h00; // unmapped and write-only read zero
			endcase
		end
		// frame state machine
		if (lk_q[2])
		begin
			next_s.st = pfp_pkg::ST_IDLE; // select high aborts any frame
		end
		else
		begin
			case (s.st)
				pfp_pkg::ST_IDLE:
				begin
					next_s.st  = pfp_pkg::ST_CMD;
					next_s.cnt = 5'd8;
				end
				pfp_pkg::ST_CMD:
					if (lk_rise[0])
					begin
						next_s.rw = lk_q[1];
						next_s.st = pfp_pkg::ST_ADDR;
					end
				pfp_pkg::ST_ADDR:
					if (lk_rise[0])
					begin
						next_s.sh  = wd;
						next_s.cnt = s.cnt - 5'd1;
						if (s.cnt == 5'd1)
						begin
							next_s.addr = wd;
							next_s.st   = pfp_pkg::ST_DATA;
							next_s.cnt  = 5'h09; // one spare count marks the read load
						end
					end
				pfp_pkg::ST_DATA:
				begin
					// load read data in the first data cycle only; a link edge is
					// at least HALF cycles away, so the load never meets a shift
					if (s.cnt == 5'h09)
					begin
						next_s.sh  = s.rw ? rd : 8'h00;
						next_s.cnt = 5'h08;
					end
					// a read shifts out on falls, a write shifts in on rises;
					// shifting on both would skip every other bit
					if (lk_fall[0] && s.rw)
					begin
						next_s.miso = s.sh[7];
						next_s.sh   = {s.sh[6:0], 1'b0};
					end
					if (lk_rise[0])
					begin
						next_s.sh  = s.rw ? s.sh : wd;
						next_s.cnt = s.cnt - 5'd1;
						if (s.cnt == 5'd1)
						begin
							next_s.st = pfp_pkg::ST_IDLE;
							next_s.cnt = 5'd0;
							if (!s.rw)
							begin
								// register writes, all in the current page
								if (s.addr == pfp_pkg::OFS_PAGE)
									next_s.page = wd;
								else if (pi[3])
								begin
									case (s.addr)
										pfp_pkg::OFS_LOCK:
											next_s.lock_cfg[pi[2:0]] = wd;
										pfp_pkg::OFS_STSEL:
											next_s.stsel[pi[2:0]] = wd;
										pfp_pkg::OFS_FUSECMD:
											if (wd[7:pfp_pkg::CMD_LO] == pfp_pkg::FUSE_GO)
											begin
												next_s.fw      = 1'b1;
												next_s.fw_page = pi[2:0];
											end
										pfp_pkg::OFS_MASK:
											if (is_loop)
												next_s.mask[li] = wd[0];
										pfp_pkg::OFS_NOTIFY:
											if (is_loop && wd[0])
												next_s.notify[li] = lock_loss[li] & s.mask[li];
										pfp_pkg::OFS_FORCE:
											if (is_main)
												next_s.force_ovr = wd[6:0];
										pfp_pkg::OFS_ENABLE:
											if (is_main)
												next_s.force_en = wd[6:0];
										default: ;
									endcase
								end
							end
						end
					end
				end
				default: next_s.st = pfp_pkg::ST_IDLE;
			endcase
		end
		// power and lock decode registered for clean outputs
		next_s.pwr = s.force_ovr & s.force_en;
		next_s.wake = ~s.lock_cfg[0][pfp_pkg::WAKE_BIT];
		for (int i = 0; i < pfp_pkg::NPAGE; i++)
			next_s.locked[i] = (s.lock_cfg[i][pfp_pkg::LOCK_HI:pfp_pkg::LOCK_LO] == pfp_pkg::LOCK_ON);
	end
	////////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s      <= '0;
			s.page <= pfp_pkg::PAGE_RESET;
			s.wake <= 1'b1; // manual wake-up in force until main page says otherwise
		end
		else if (ce)
			s <= next_s;
	end
	////////////////////////////////////////////////////////////////////////////
	// outputs straight from flops
	assign link.miso        = s.miso;
	assign subsys_power_up  = s.pwr;
	assign subsys_force     = s.force_ovr;
	assign manual_wake_en   = s.wake;
	assign page_fuse_locked = s.locked;
	assign fuse_write_start = s.fw;
	assign fuse_write_page  = s.fw_page;
	assign lock_loss_notify = s.notify;
endmodule // pfp_device

// *** inc/pfp_pkg.sv ***
/*
 * shared constants, types and page decode for the paged fuse program and status link.
 * assumes both ends run on one 100 MHz system clock.
 */
// What this block does
// - page-select write picks page; loops are 0A-0D
// - select 0x20 makes readback show loop state
// - loop state reads 8 wait, 0 idle, 48 active
// - mask 0x04 value 0x01 unmasks lock-loss notify
// - live status bit0 is one when out of lock
// - host powers subsystem up before its fuse write
// - main 0xE0 bits 0-6 force override per subsystem
// - main 0xE1 bits 0-6 power subsystems up
// - lock field 7:6 equal one locks page fuses
// - command field 7:3 equal 0x0C starts fuse write
// - main lock register bit4 ends manual wake-up
// - host ends manual wake-up as last step; the bench drops it with the main lock write, before the main fuse write
// - page-select reads back current page
// - codes 00-03 select main, monitor, input, output
// - host writes fuses only in program wait state
// - notify clears by writing one; mask enables it
package pfp_pkg;
	////////////////////////////////////////////////////////////////////////////
	// register offsets
	localparam logic [7:0] OFS_LIVE    = 8'h02; // lock-loss live status
	localparam logic [7:0] OFS_NOTIFY  = 8'h03; // sticky lock-loss notify
	localparam logic [7:0] OFS_MASK    = 8'h04; // notify mask
	localparam logic [7:0] OFS_FUSECMD = 8'h0F; // fuse write command
	localparam logic [7:0] OFS_LOCK    = 8'h2F; // fuse lock and wake config
	localparam logic [7:0] OFS_STATE   = 8'hD0; // state readback
	localparam logic [7:0] OFS_STSEL   = 8'hD1; // state readback select
	localparam logic [7:0] OFS_FORCE   = 8'hE0; // subsystem force override
	localparam logic [7:0] OFS_ENABLE  = 8'hE1; // subsystem force enable
	localparam logic [7:0] OFS_PAGE    = 8'hFF; // page select
	////////////////////////////////////////////////////////////////////////////
	// page codes and field values
	localparam logic [7:0] PAGE_MAIN   = 8'h00;
	localparam logic [7:0] PAGE_OUTPUT = 8'h03;
	localparam logic [7:0] PAGE_LOOP_A = 8'h0A;
	localparam logic [7:0] PAGE_LOOP_D = 8'h0D;
	localparam logic [7:0] PAGE_RESET  = 8'h00;
	localparam logic [7:0] STSEL_LOOP  = 8'h20; // loop state select value
	localparam logic [4:0] FUSE_GO     = 5'h0C; // command field value
	localparam logic [1:0] LOCK_ON     = 2'h1;  // lock field value
	localparam int         LOCK_HI     = 7;
	localparam int         LOCK_LO     = 6;
	localparam int         CMD_LO      = 3;
	localparam int         WAKE_BIT    = 4;
	localparam int         LIVE_BIT    = 0;
	localparam int         NSUB        = 7;     // monitor..loop D
	localparam int         NPAGE       = 8;
	localparam int         NLOOP       = 4;
	localparam logic [2:0] LOOP_IDX0   = 3'h4;  // page index of loop A
	////////////////////////////////////////////////////////////////////////////
	// loop controller state inputs and readback codes
	localparam logic [1:0] LST_IDLE    = 2'h0;
	localparam logic [1:0] LST_WAIT    = 2'h1;
	localparam logic [1:0] LST_ACTIVE  = 2'h2;
	localparam logic [7:0] CODE_IDLE   = 8'h00; // 0
	localparam logic [7:0] CODE_WAIT   = 8'h08; // 8
	localparam logic [7:0] CODE_ACTIVE = 8'h30; // 48
	////////////////////////////////////////////////////////////////////////////
	// link framing and timing
	localparam int         FRAME_BITS  = 17;    // rw, 8 address, 8 data
	localparam int         SYS_MHZ     = 100;
	localparam int         LINK_NS     = 160;   // link clock period
	localparam int         HALF_CYC    = (LINK_NS * SYS_MHZ) / 2000;
	////////////////////////////////////////////////////////////////////////////
	// frame states, the device ones gray along the usual path
	typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_CMD = 2'b01, ST_ADDR = 2'b11, ST_DATA = 2'b10} pfp_dev_st_t;
	typedef enum logic [1:0] {HS_IDLE = 2'b00, HS_SHIFT = 2'b01, HS_GAP = 2'b11} pfp_host_st_t;
	// page code to {valid, index}; index 0..3 fixed pages, 4..7 loops
	function automatic logic [3:0] page_index(input logic [7:0] code);
		if (code <= PAGE_OUTPUT)
			page_index = {1'b1, code[2:0]};
		else if (code >= PAGE_LOOP_A && code <= PAGE_LOOP_D)
			page_index = {1'b1, 1'b1, code[1:0] - 2'h2};
		else
			page_index = 4'h0;
	endfunction
endpackage

// *** inc/pfp_link_if.sv ***
/*
 * serial register link between host and device.
 * assumes the testbench instances it and ties both ends to it.
 */
`timescale 1ns/1ps
interface pfp_link_if;
	logic link_clk;   // made by the host
	logic sel_n;      // frame select, active low
	logic mosi;       // host to device data
	logic miso;       // device to host data
	modport host (output link_clk, output sel_n, output mosi, input miso);
	modport dev  (input link_clk, input sel_n, input mosi, output miso);
endinterface // pfp_link_if

// *** hdl/pfp_sync.sv ***
/*
 * two-stage synchroniser with edge detect on the settled stage.
 * assumes inputs come from outside the clk_sys domain.
 */
`timescale 1ns/1ps
module pfp_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk_sys,
	input  wire logic             reset_n,
	input  wire logic             ce,
	// asynchronous input
	input  wire logic [WIDTH-1:0] din,
	// synchronised outputs
	output logic      [WIDTH-1:0] q,
	output logic      [WIDTH-1:0] rise,
	output logic      [WIDTH-1:0] fall
);
	typedef struct packed {
		logic [WIDTH-1:0] s1; // metastable stage, read only by s2
		logic [WIDTH-1:0] s2; // settled
		logic [WIDTH-1:0] s3; // previous settled value
	} pfp_sync_t;
	pfp_sync_t s, next_s;
	////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb
	begin
		next_s    = s;
		next_s.s1 = din;
		next_s.s2 = s.s1;
		next_s.s3 = s.s2;
	end
	// registers, frozen while ce is low
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			s <= '0;
		else if (ce)
			s <= next_s;
	end
	assign q    = s.s2;
	assign rise = s.s2 & ~s.s3;
	assign fall = ~s.s2 & s.s3;
endmodule // pfp_sync

// *** hdl/pfp_host.sv ***
/*
 * host end: turns single register requests into link frames and returns read data.
 * assumes the user sequences pages, power-up and fuse writes in the documented order.
 */
`timescale 1ns/1ps
module pfp_host #(
	parameter int HALF = pfp_pkg::HALF_CYC // clk_sys cycles per link half period
) (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       reset_n,
	input  wire logic       ce,
	// link
	pfp_link_if.host        link,
	// request
	input  wire logic       req,
	input  wire logic       req_read,
	input  wire logic [7:0] req_addr,
	input  wire logic [7:0] req_wdata,
	// answer
	output logic            busy,
	output logic            done,
	output logic      [7:0] rdata
);
	typedef struct packed {
		pfp_pkg::pfp_host_st_t st;    // frame state
		logic [7:0]            div;   // half-period counter
		logic [4:0]            bits;  // rising edges so far
		logic [16:0]           tx;    // outgoing frame
		logic [7:0]            rx;    // incoming bits
		logic                  clk;   // link clock out
		logic                  sel_n; // frame select out
		logic                  busy;
		logic                  done;
		logic [7:0]            rdata;
	} pfp_host_t;
	pfp_host_t s, next_s;
	logic miso_q;
	////////////////////////////////////////////////////////////////////////////
	// miso comes back from the device domain
	pfp_sync #(.WIDTH(1)) u_sync (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.ce      (ce),
		.din     (link.miso),
		.q       (miso_q),
		.rise    (),
		.fall    ()
	);
	////////////////////////////////////////////////////////////////////////////
	// clock divider and frame sequencing
	always_comb
	begin
		logic tick;
		tick        = (s.div == 8'(HALF - 1));
		next_s      = s;
		next_s.done = 1'b0;
		next_s.div  = tick ? 8'h00 : s.div + 8'h01;
		case (s.st)
			pfp_pkg::HS_IDLE:
			begin
				next_s.div = 8'h00;
				if (req)
				begin
					// ordering of power-up, fuse writes and wake-up is the user's job
					next_s.st    = pfp_pkg::HS_SHIFT;
					next_s.tx    = {req_read, req_addr, req_wdata};
					next_s.bits  = 5'd0;
					next_s.sel_n = 1'b0;
					next_s.busy  = 1'b1;
				end
			end
			pfp_pkg::HS_SHIFT:
				if (tick)
				begin
					next_s.clk = ~s.clk;
					if (!s.clk)
					begin
						next_s.rx   = {s.rx[6:0], miso_q};
						next_s.bits = s.bits + 5'd1;
					end
					else if (s.bits == 5'(pfp_pkg::FRAME_BITS))
					begin
						next_s.st    = pfp_pkg::HS_GAP;
						next_s.sel_n = 1'b1;
						next_s.rdata = s.rx;
					end
					else
						next_s.tx = {s.tx[15:0], 1'b0};
				end
			pfp_pkg::HS_GAP:
				// hold select high for one half period (HALF cycles) so the device sees the frame end
				if (tick && s.clk == 1'b0 && s.div == 8'(HALF - 1))
				begin
					next_s.st   = pfp_pkg::HS_IDLE;
					next_s.busy = 1'b0;
					next_s.done = 1'b1;
				end
			default: next_s.st = pfp_pkg::HS_IDLE;
		endcase
	end
	////////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s       <= '0;
			s.sel_n <= 1'b1;
		end
		else if (ce)
			s <= next_s;
	end
	// outputs straight from flops
	assign link.link_clk = s.clk;
	assign link.sel_n    = s.sel_n;
	assign link.mosi     = s.tx[16];
	assign busy          = s.busy;
	assign done          = s.done;
	assign rdata         = s.rdata;
endmodule // pfp_host

// *** sim/pfp_asserts.sv ***
/*
 * checker for the shared link and the device status outputs.
 * assumes the bench wires it beside the link and the host runs its default half period of 8.
 */
`timescale 1ns/1ps
module pfp_asserts (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       reset_n,
	// link
	input  wire logic       link_clk,
	input  wire logic       sel_n,
	input  wire logic       mosi,
	input  wire logic       miso,
	// device side
	input  wire logic       manual_wake_en,
	input  wire logic       fuse_write_start,
	input  wire logic [3:0] lock_loss,
	input  wire logic [3:0] lock_loss_notify
);
	////////////////////////////////////////////////////////////////////////////
	logic       clk_q;    // link clock one cycle late
	logic [4:0] rise_cnt; // link rises seen in this frame

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	// count link rises while framed; the gap clears it
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			clk_q    <= 1'b0;
			rise_cnt <= 5'h00;
		end
		else
		begin
			clk_q <= link_clk;
			if (sel_n)
				rise_cnt <= 5'h00;
			else if (link_clk && !clk_q)
				rise_cnt <= rise_cnt + 5'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// framing: a short frame would shift a page code into the wrong register
	a_idle_clock_low: assert property (sel_n |-> !link_clk)
		else $error("link clock high outside a frame");
	a_frame_rise_count: assert property ($rose(sel_n) |-> rise_cnt == 5'h11)
		else $error("frame did not carry 17 link clocks");
	a_clock_high_time: assert property ($rose(link_clk) |-> link_clk [*8])
		else $error("link clock high phase too short");
	a_frame_length: assert property ($fell(sel_n) |-> ##[260:320] $rose(sel_n))
		else $error("frame length out of range");
	a_frame_gap: assert property ($rose(sel_n) |-> sel_n [*3])
		else $error("gap between frames too short");
	// data lines hold while the clock is high
	a_mosi_stable_high: assert property (!sel_n && link_clk && $past(link_clk) |-> $stable(mosi))
		else $error("host data moved while clock high");
	a_miso_stable_high: assert property (!sel_n && link_clk && $past(link_clk) |-> $stable(miso))
		else $error("device data moved while clock high");
	// device outputs tied to their causes
	a_fuse_pulse_frame: assert property (fuse_write_start |-> !sel_n ##1 !fuse_write_start)
		else $error("fuse write pulse outside a frame or too long");
	a_wake_only_write: assert property ($fell(manual_wake_en) |-> !sel_n)
		else $error("manual wake-up dropped without a write");
	a_notify_needs_loss: assert property ((lock_loss_notify & ~$past(lock_loss_notify) & ~$past(lock_loss)) == 4'h0)
		else $error("notify set without lock loss");

	c_fuse_write: cover property (fuse_write_start);
	c_wake_off: cover property ($fell(manual_wake_en));
	c_notify_set: cover property ($rose(lock_loss_notify[2]));
endmodule // pfp_asserts

// *** sim/paged_fuse_program_and_status_bench.sv ***
/*
 * bench joining host and device over the link; register calls with expected values.
 * assumes the host keeps its default half period and ce is held high.
 */
`timescale 1ns/1ps
module paged_fuse_program_and_status_bench;
	// clock, reset and host request
	logic       clk_sys;
	logic       reset_n;
	logic       req;
	logic       req_read;
	logic [7:0] req_addr;
	logic [7:0] req_wdata;
	// host answer
	logic       busy;
	logic       done;
	logic [7:0] rdata;
	// device status and control
	logic [3:0] lock_loss;
	logic [7:0] loop_state;
	logic [6:0] subsys_power_up;
	logic [6:0] subsys_force;
	logic       manual_wake_en;
	logic [7:0] page_fuse_locked;
	logic       fuse_write_start;
	logic [2:0] fuse_write_page;
	logic [3:0] lock_loss_notify;
	// bookkeeping
	int         fails;
	int         n_tests;
	int         fw_cnt;    // fuse write pulses seen
	logic [2:0] fw_page;   // page of the last pulse
	logic [7:0] rd;        // last read value
	logic [7:0] lock_exp;  // pages expected locked
	logic [7:0] codes [8]; // page walk, main page last
	logic [2:0] idx;

	////////////////////////////////////////////////////////////////////////////
	pfp_link_if link_bus ();
	pfp_host pfp_host_inst (.clk_sys(clk_sys), .reset_n(reset_n), .ce(1'b1), .link(link_bus.host),
		.req(req), .req_read(req_read), .req_addr(req_addr), .req_wdata(req_wdata),
		.busy(busy), .done(done), .rdata(rdata));
	pfp_device pfp_device_inst (.clk_sys(clk_sys), .reset_n(reset_n), .ce(1'b1), .link(link_bus.dev),
		.lock_loss(lock_loss), .loop_state(loop_state), .subsys_power_up(subsys_power_up),
		.subsys_force(subsys_force), .manual_wake_en(manual_wake_en), .page_fuse_locked(page_fuse_locked),
		.fuse_write_start(fuse_write_start), .fuse_write_page(fuse_write_page),
		.lock_loss_notify(lock_loss_notify));
	pfp_asserts pfp_asserts_inst (.clk_sys(clk_sys), .reset_n(reset_n), .link_clk(link_bus.link_clk),
		.sel_n(link_bus.sel_n), .mosi(link_bus.mosi), .miso(link_bus.miso),
		.manual_wake_en(manual_wake_en), .fuse_write_start(fuse_write_start),
		.lock_loss(lock_loss), .lock_loss_notify(lock_loss_notify));

	////////////////////////////////////////////////////////////////////////////
	// clock source
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// fuse pulses are one cycle wide, so catch them here
	always @(posedge clk_sys)
	begin
		if (fuse_write_start === 1'b1)
		begin
			fw_cnt  <= fw_cnt + 1;
			fw_page <= fuse_write_page;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
			fails++;
		end
	endtask

	// one frame; done is polled on the falling edge where it has settled
	task automatic xfer(input logic rw, input logic [7:0] a, input logic [7:0] d);
		int i;
		@(posedge clk_sys);
		req       <= 1'b1;
		req_read  <= rw;
		req_addr  <= a;
		req_wdata <= d;
		@(posedge clk_sys);
		req <= 1'b0;
		i = 0;
		@(negedge clk_sys);
		check("busy", 8'(busy), 8'h01);
		while (done !== 1'b1 && i < 1000)
		begin
			@(negedge clk_sys);
			i++;
		end
		if (i >= 1000)
		begin
			$display("unexpected done: expected 1 seen %b", done);
			fails++;
			print_verdict();
		end
		rd = rdata;
		check("busy", 8'(busy), 8'h00);
		// end on a rising edge so later stimulus lands on the clock edge
		@(posedge clk_sys);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		xfer(1'b0, a, d);
	endtask

	task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
		xfer(1'b1, a, 8'h00);
		check(what, rd, exp);
	endtask

	////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		reset_n    = 1'b0;
		req        = 1'b0;
		req_read   = 1'b0;
		req_addr   = 8'h00;
		req_wdata  = 8'h00;
		lock_loss  = 4'h0;
		loop_state = 8'h00;
		fails      = 0;
		n_tests    = 0;
		fw_cnt     = 0;
		fw_page    = 3'h0;
		lock_exp   = 8'h00;
		codes      = '{8'h02, 8'h01, 8'h03, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h00};
		repeat (16) @(posedge clk_sys);
		reset_n <= 1'b1;
		rdchk("page", 8'hFF, 8'h00);
		check("wake", 8'(manual_wake_en), 8'h01);
		// power up before any burn; partial enable shows bit order
		wr(8'hE0, 8'h7F);
		wr(8'hE1, 8'h15);
		check("power", 8'(subsys_power_up), 8'h15);
		check("force", 8'(subsys_force), 8'h7F);
		wr(8'hE1, 8'h7F);
		rdchk("enable", 8'hE1, 8'h7F);
		// every loop waits for program commands before the burns
		loop_state <= 8'h55;
		// lock and burn every page; main last also drops manual wake-up
		foreach (codes[k])
		begin
			idx = (codes[k] < 8'h0A) ? codes[k][2:0] : 3'(codes[k] - 8'h06);
			wr(8'hFF, codes[k]);
			rdchk("page", 8'hFF, codes[k]);
			wr(8'h2F, (k == 7) ? 8'h50 : 8'h40);
			lock_exp[idx] = 1'b1;
			check("locked", page_fuse_locked, lock_exp);
			wr(8'h0F, 8'h00);
			wr(8'h0F, 8'h60);
			check("burns", 8'(fw_cnt), 8'(k + 1));
			check("burn page", 8'(fw_page), 8'(idx));
		end
		check("wake", 8'(manual_wake_en), 8'h00);
		rdchk("lock cfg", 8'h2F, 8'h50);
		// loop B state readback; wrong select must hide it
		wr(8'hFF, 8'h0B);
		loop_state <= 8'h08;
		wr(8'hD1, 8'h40);
		rdchk("state", 8'hD0, 8'h00);
		wr(8'hD1, 8'h20);
		for (int s = 0; s < 3; s++)
		begin
			loop_state <= 8'(s << 2);
			rdchk("state", 8'hD0, (s == 0) ? 8'h00 : (s == 1) ? 8'h08 : 8'h30);
		end
		// lock loss on loop C, masked then unmasked, then cleared
		wr(8'hFF, 8'h0C);
		lock_loss <= 4'h4;
		rdchk("live", 8'h02, 8'h01);
		check("notify", 8'(lock_loss_notify), 8'h00);
		wr(8'h04, 8'h01);
		rdchk("mask", 8'h04, 8'h01);
		check("notify", 8'(lock_loss_notify), 8'h04);
		// clearing while still out of lock: the set wins
		wr(8'h03, 8'h01);
		check("notify", 8'(lock_loss_notify), 8'h04);
		lock_loss <= 4'h0;
		rdchk("live", 8'h02, 8'h00);
		wr(8'h03, 8'h01);
		check("notify", 8'(lock_loss_notify), 8'h00);
		// unknown page code: held and read back, nothing else reachable
		wr(8'hFF, 8'h05);
		rdchk("page", 8'hFF, 8'h05);
		wr(8'h2F, 8'h40);
		rdchk("bad page", 8'h2F, 8'h00);
		check("locked", page_fuse_locked, 8'hFF);
		print_verdict();
	end
endmodule // paged_fuse_program_and_status_bench
